// ===== design/speed_fifo.sv
// Purpose: Dual clock first-in first-out buffer between a producer and a consumer.
// Assumes: Producer and consumer drive their requests on their own clocks.
// Notes: Output shows the head word whenever nothing_left is low.
`default_nettype none
`include "speed_fifo_map.svh"
module speed_fifo
	import speed_fifo_pkg::*;
#(
	parameter int DATA_W = `FIFO_DATA_W,
	parameter int ADDR_W = `FIFO_ADDR_W
)
(
	// Reset
	input  wire logic              rst_n,
	// Producer side
	input  wire logic              push_clk,
	input  wire logic              push_req,
	input  wire logic [DATA_W-1:0] push_word,
	output var  logic              no_room,
	// Consumer side
	input  wire logic              pop_clk,
	input  wire logic              pop_req,
	output var  logic [DATA_W-1:0] pop_word,
	output var  logic              nothing_left
);
	// Power of two depth keeps the Gray pointers single step
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [ADDR_W:0] FULL_CNT = DEPTH[ADDR_W:0];
	localparam logic [ADDR_W:0] ONE = {{ADDR_W{1'b0}}, 1'b1};
	localparam logic [ADDR_W:0] EARLY_CNT = FULL_CNT - ONE;
	localparam logic [ADDR_W:0] PTR_RST = (ADDR_W + 1)'(`FIFO_PTR_RST);
	localparam logic [DATA_W-1:0] WORD_RST = DATA_W'(`FIFO_WORD_RST);

	function automatic logic [ADDR_W:0] gray_to_bin(input logic [ADDR_W:0] g);
		logic [ADDR_W:0] b;
		b[ADDR_W] = g[ADDR_W];
		for (int i = ADDR_W - 1; i >= 0; i--)
		begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : gray_to_bin

	logic [DATA_W-1:0] mem [DEPTH];

	// Reset release per domain; assertion stays asynchronous
	rst_sync_t         w_rs;
	rst_sync_t         r_rs;
	logic              w_rst_n;
	logic              r_rst_n;

	// Producer domain state
	logic [ADDR_W:0]   wbin;
	logic [ADDR_W:0]   wgray;
	logic [ADDR_W:0]   rgray_s1;
	logic [ADDR_W:0]   rgray_s2;

	// Consumer domain state
	logic [ADDR_W:0]   rbin;
	logic [ADDR_W:0]   rgray;
	logic [ADDR_W:0]   wgray_s1;
	logic [ADDR_W:0]   wgray_s2;

	// Reset synchronisers
	always_ff @(posedge push_clk or negedge rst_n)
	begin
		if (!rst_n)
			w_rs <= '0;
		else
			w_rs <= {w_rs[0], 1'b1};
	end

	always_ff @(posedge pop_clk or negedge rst_n)
	begin
		if (!rst_n)
			r_rs <= '0;
		else
			r_rs <= {r_rs[0], 1'b1};
	end

	assign w_rst_n = w_rs[`FIFO_SYNC_W-1];
	assign r_rst_n = r_rs[`FIFO_SYNC_W-1];

	// Producer side decode
	wire              push_ok    = push_req && !no_room;
	wire [ADDR_W:0]   next_wbin  = wbin + {{ADDR_W{1'b0}}, push_ok};
	wire [ADDR_W:0]   next_wgray = (next_wbin >> 1) ^ next_wbin;
	wire [ADDR_W:0]   rbin_w     = gray_to_bin(rgray_s2);
	wire [ADDR_W:0]   fill_now   = wbin - rbin_w;
	wire [ADDR_W:0]   fill_next  = next_wbin - rbin_w;
	wire              stream_on  = push_ok;
	// A stalled producer is told early, so the last slot only fills in a burst
	wire              next_no_room = (fill_next == FULL_CNT)
		|| ((fill_next == EARLY_CNT) && !stream_on);

	always_ff @(posedge push_clk)
	begin
		if (push_ok)
			mem[wbin[ADDR_W-1:0]] <= push_word;
	end

	always_ff @(posedge push_clk or negedge w_rst_n)
	begin
		if (!w_rst_n)
		begin
			wbin    <= PTR_RST;
			wgray   <= PTR_RST;
			no_room <= `FIFO_NO_ROOM_RST;
		end
		else
		begin
			wbin    <= next_wbin;
			wgray   <= next_wgray;
			no_room <= next_no_room;
		end
	end

	// Read pointer into the producer domain
	// First stage may go metastable, so only the second stage is read
	always_ff @(posedge push_clk or negedge w_rst_n)
	begin
		if (!w_rst_n)
		begin
			rgray_s1 <= PTR_RST;
			rgray_s2 <= PTR_RST;
		end
		else
		begin
			rgray_s1 <= rgray;
			rgray_s2 <= rgray_s1;
		end
	end

	// Consumer side decode
	wire              pop_ok     = pop_req && !nothing_left;
	wire [ADDR_W:0]   next_rbin  = rbin + {{ADDR_W{1'b0}}, pop_ok};
	wire [ADDR_W:0]   next_rgray = (next_rbin >> 1) ^ next_rbin;
	wire              next_empty = next_rgray == wgray_s2;
	// Reading one slot ahead lets the head word land with the flag edge
	wire [DATA_W-1:0] head_word  = mem[next_rbin[ADDR_W-1:0]];

	always_ff @(posedge pop_clk or negedge r_rst_n)
	begin
		if (!r_rst_n)
		begin
			rbin         <= PTR_RST;
			rgray        <= PTR_RST;
			nothing_left <= `FIFO_EMPTY_RST;
			pop_word     <= WORD_RST;
		end
		else
		begin
			rbin         <= next_rbin;
			rgray        <= next_rgray;
			nothing_left <= next_empty;
			pop_word     <= head_word;
		end
	end

	// Write pointer into the consumer domain
	always_ff @(posedge pop_clk or negedge r_rst_n)
	begin
		if (!r_rst_n)
		begin
			wgray_s1 <= PTR_RST;
			wgray_s2 <= PTR_RST;
		end
		else
		begin
			wgray_s1 <= wgray;
			wgray_s2 <= wgray_s1;
		end
	end

	// Overflow and underflow are left to the caller: no error outputs

	// Producer side checks
	push_store_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		push_req && !no_room |=> (wbin - $past(wbin)) == ONE
			&& $past(push_word) == mem[$past(wbin[ADDR_W-1:0])])
	else
		$error("accepted push not stored");

	full_block_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		no_room |=> $stable(wbin))
	else
		$error("push taken while no room");

	overflow_lost_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		push_req && no_room |=> wbin == $past(wbin) && fill_now <= FULL_CNT)
	else
		$error("overflow word entered the buffer");

	full_depth_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		fill_now == FULL_CNT |-> no_room)
	else
		$error("no room missing at full depth");

	sequence slow_fill_s;
		fill_now == EARLY_CNT && !push_ok ##1 fill_now == EARLY_CNT;
	endsequence

	early_full_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		slow_fill_s |-> no_room)
	else
		$error("no room missing one word early");

	room_flag_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		no_room |-> (wbin - $past(rbin_w)) >= EARLY_CNT)
	else
		$error("no room raised below threshold");

	wgray_step_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		$onehot0(wgray ^ $past(wgray)) && wgray == ((wbin >> 1) ^ wbin))
	else
		$error("write gray pointer stepped badly");

	push_reset_a: assert property (
		@(posedge push_clk) disable iff (!rst_n)
		$rose(w_rst_n) |-> wbin == PTR_RST && !no_room)
	else
		$error("producer side not cleared by reset");

	idle_push_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		!push_req |=> $stable(wbin))
	else
		$error("write pointer moved without a push");

	room_free_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		!no_room |-> fill_now < FULL_CNT)
	else
		$error("no room low with buffer full");

	fill_bound_a: assert property (
		@(posedge push_clk) disable iff (!w_rst_n)
		fill_now <= FULL_CNT)
	else
		$error("fill level beyond depth");

	// Consumer side checks
	sequence pop_taken_s;
		pop_req && !nothing_left;
	endsequence

	pop_head_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		pop_taken_s |=> (rbin - $past(rbin)) == ONE)
	else
		$error("pop did not advance head");

	head_word_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		!nothing_left |-> pop_word == mem[rbin[ADDR_W-1:0]])
	else
		$error("output is not the oldest word");

	empty_hold_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		nothing_left |=> $stable(rbin))
	else
		$error("pop taken while nothing left");

	empty_cause_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		$rose(nothing_left) |-> $past(pop_ok))
	else
		$error("nothing left rose without a pop");

	word_hold_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		!nothing_left && !pop_req |=> $stable(pop_word))
	else
		$error("output word changed without a pop");

	rgray_step_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		$onehot0(rgray ^ $past(rgray)) && rgray == ((rbin >> 1) ^ rbin))
	else
		$error("read gray pointer stepped badly");

	pop_reset_a: assert property (
		@(posedge pop_clk) disable iff (!rst_n)
		$rose(r_rst_n) |-> rbin == PTR_RST && nothing_left)
	else
		$error("consumer side not cleared by reset");

	idle_pop_a: assert property (
		@(posedge pop_clk) disable iff (!r_rst_n)
		!pop_req |=> $stable(rbin))
	else
		$error("read pointer moved without a pop");

endmodule : speed_fifo
`default_nettype wire

// ===== design/speed_fifo_map.svh
// Purpose: Constants for the dual clock speed matching FIFO.
// Assumes: Included by bare name from the FIFO design file.
// Notes: Depth is two to the power of the address width.
//
// Notes on behaviour
// - A push request with no-room low stores the push word on the producer clock edge.
// - While no-room is high, push requests are ignored and nothing is stored.
// - A pop request with nothing-left low hands over the oldest stored word.
// - While nothing-left is high pops are ignored and the output is invalid.
// - A push while no-room is high is an overflow and that word is lost.
// - A pop while nothing-left is high is an underflow and its data is undefined.
// - There are no overflow or underflow outputs, only the two flags.
// - Back to back pushes fill the whole depth, slower traffic shows no-room one word early.
// - One asynchronous reset input clears both clock domains.
// - The no-room flag is produced on the producer clock.
// - The nothing-left flag is produced on the consumer clock.
// - The output word is driven on the consumer clock and held at least one cycle.
// - The two clocks are independent and a running clock moves its own pointer only with its enable.
// - Word width and depth are parameters.
`ifndef SPEED_FIFO_MAP_SVH
`define SPEED_FIFO_MAP_SVH
`define FIFO_DATA_W 8
`define FIFO_ADDR_W 3
`define FIFO_SYNC_W 2
`define FIFO_PTR_RST 32'h0000_0000
`define FIFO_WORD_RST 32'h0000_0000
`define FIFO_NO_ROOM_RST 1'b0
`define FIFO_EMPTY_RST 1'b1
`endif

// ===== design/speed_fifo_pkg.sv
// Purpose: Shared types of the speed matching FIFO.
// Assumes: Constants come from the map header.
// Notes: Reset synchroniser stages share one type in both domains.
`default_nettype none
`include "speed_fifo_map.svh"
package speed_fifo_pkg;
	typedef logic [`FIFO_SYNC_W-1:0] rst_sync_t;
endpackage : speed_fifo_pkg
`default_nettype wire

// ===== tb/pop_model.sv
// Purpose: Consumer logic model on the pop clock.
// Assumes: The bench raises go to let it pop.
// Notes: Pops even when empty, so underflow is exercised.
`default_nettype none
module pop_model
(
	// Consumer clock and bench control
	input  wire logic       pop_clk,
	input  wire logic       go,
	// Fifo read side
	input  wire logic       nothing_left,
	input  wire logic [7:0] pop_word,
	output var  logic       pop_req,
	// Received words
	output var  logic       got,
	output var  logic [7:0] got_word
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(negedge pop_clk)
		pop_req <= go;
	// Words shown while empty are not valid, so they are never taken
	always @(posedge pop_clk)
	begin
		got <= pop_req && !nothing_left;
		got_word <= pop_word;
	end
endmodule : pop_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the speed matching fifo.
// Assumes: Default width 8 and depth 8.
// Notes: Pop clock has a 52 ns period and a 7 ns offset to stay unrelated.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       rst_n, push_clk, push_req, pop_clk, go, no_room, nothing_left, pop_req, got;
	logic [7:0] push_word, pop_word, got_word;
	logic [7:0] rx[$];
	int         failures, checks_done;
	speed_fifo speed_fifo_i (.rst_n(rst_n), .push_clk(push_clk), .push_req(push_req),
		.push_word(push_word), .no_room(no_room), .pop_clk(pop_clk), .pop_req(pop_req),
		.pop_word(pop_word), .nothing_left(nothing_left));
	pop_model pop_model_i (.pop_clk(pop_clk), .go(go), .nothing_left(nothing_left),
		.pop_word(pop_word), .pop_req(pop_req), .got(got), .got_word(got_word));
	initial
	begin
		push_clk = 1'b0;
		forever #20 push_clk = ~push_clk;
	end
	initial
	begin
		pop_clk = 1'b0;
		#7;
		forever #26 pop_clk = ~pop_clk;
	end
	always @(negedge pop_clk)
		if (got === 1'b1)
			rx.push_back(got_word);
	task check_flag(input string name, input logic exp, input logic seen);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
		end
	endtask : check_flag
	task check_word(input string name, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check_word
	task finish_test;
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	// Offers n words, with gap idle cycles after each, consumer stalled
	task fill(input int n, input int gap);
		for (int i = 0; i < n; i++)
		begin
			@(negedge push_clk);
			push_req = 1'b1;
			push_word = 8'h40 + i[7:0];
			repeat (gap)
			begin
				@(negedge push_clk);
				push_req = 1'b0;
			end
		end
		@(negedge push_clk);
		push_req = 1'b0;
		repeat (8) @(negedge push_clk);
	endtask : fill
	// Pops for a fixed span, keeps popping past empty, then checks order
	task drain(input int n);
		rx.delete();
		@(negedge pop_clk);
		go <= 1'b1;
		repeat (40) @(negedge pop_clk);
		go <= 1'b0;
		check_word("count", n[7:0], 8'(rx.size()));
		for (int i = 0; i < n; i++)
			check_word("word", 8'h40 + i[7:0], rx[i]);
		check_flag("empty", 1'b1, nothing_left);
	endtask : drain
	initial
	begin
		rst_n = 1'b0;
		push_req = 1'b0;
		push_word = 8'h00;
		go = 1'b0;
		failures = 0;
		checks_done = 0;
		repeat (2) @(negedge push_clk);
		check_flag("rst no_room", 1'b0, no_room);
		check_flag("rst nothing_left", 1'b1, nothing_left);
		check_word("rst pop_word", 8'h00, pop_word);
		rst_n = 1'b1;
		repeat (20) @(negedge push_clk);
		check_flag("idle", 1'b1, nothing_left);
		fill(9, 0);
		check_flag("full stream", 1'b1, no_room);
		check_word("head", 8'h40, pop_word);
		repeat (5) @(negedge pop_clk);
		check_word("head held", 8'h40, pop_word);
		drain(8);
		fill(8, 1);
		check_flag("full slow", 1'b1, no_room);
		drain(7);
		check_flag("room again", 1'b0, no_room);
		finish_test;
	end
endmodule : testbench
`default_nettype wire
